// ==== hw/dcs_pkg.sv ====
package dcs_pkg;
  // converter clock divider: 200 MHz system clock, 25 MHz converter clock
  localparam int CLK_MHZ = 200;
  localparam int CONV_CLK_MHZ = 25;
  localparam int CONV_DIV = CLK_MHZ / CONV_CLK_MHZ;
  // acquisition window field of converter_control_one
  localparam int ACQ_LSB = 8;
  localparam int ACQ_W = 4;
  localparam int CTRL_W = 16;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 16'h0000;
  // start-to-sample delay, in half converter clocks (2.5 clocks)
  localparam int START_DLY_HALF = 5;
  // result latencies after sampling, in converter clocks
  localparam int LAT_A_FIRST = 4;
  localparam int LAT_B_FIRST = 5;
  localparam int LAT_NEXT_BASE = 3;
  localparam int LAT_SEQ_NEXT_BASE = 2;
  // system clock cycles from result update to flag
  localparam int FLAG_DLY = 2;
  localparam int CH_W = 3;
  localparam int DATA_W = 12;
  typedef enum logic [2:0] {
    DCS_IDLE, DCS_DELAY, DCS_HOLD, DCS_CONV
  } dcs_state_type;
endpackage : dcs_pkg

// ==== hw/dcs_delay_line.sv ====
`timescale 1ns/10ps
// delays a one-cycle pulse by a fixed number of system clocks
module dcs_delay_line #(
  parameter int DEPTH = 2
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_pulse,
  output logic o_pulse
);
  logic [DEPTH-1:0] pipe_q;

  // refuse a depth the shift register cannot serve
  if (DEPTH < 1) begin : g_bad_depth
    $error("depth must be at least one");
  end

  // shift register of the pulse, single stage kept apart
  if (DEPTH == 1) begin : g_one
    always_ff @(posedge i_mclk) begin
      if (i_rst) begin
        pipe_q <= '0;
      end else begin
        pipe_q <= i_pulse;
      end
    end
  end else begin : g_many
    always_ff @(posedge i_mclk) begin
      if (i_rst) begin
        pipe_q <= '0;
      end else begin
        pipe_q <= {pipe_q[DEPTH-2:0], i_pulse};
      end
    end
  end

  assign o_pulse = pipe_q[DEPTH-1];
endmodule : dcs_delay_line

// ==== hw/dcs_sequencer.sv ====
`timescale 1ns/10ps
// Behaviour
// - in dual mode one selected A/B pair with index 0 to 7 is converted.
// - with dual select high each hold pulse converts both channels.
// - a pwm event, software trigger or external start pin starts a run.
// - flags are raised a few system clocks after the result update.
// - both channels are captured together on the hold pulse falling edge.
// - the hold pulse lasts from one to sixteen converter clocks.
// - hold width is one plus the acquisition field, bits 8 to 11.
// - sampling starts two and a half converter clocks after the start.
// - first A result after four and B after five converter clocks.
// - later results follow every three plus acquisition converter clocks dual, two plus acquisition single.
// - with dual select low one channel is converted per hold pulse.
module dcs_sequencer #(
  parameter int DIV = dcs_pkg::CONV_DIV,
  parameter int FLAG_DELAY = dcs_pkg::FLAG_DLY
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [dcs_pkg::CTRL_W-1:0] i_ctrl_one,
  input wire logic i_dual_sample_select,
  input wire logic i_continuous,
  input wire logic [dcs_pkg::CH_W:0] i_channel,
  input wire logic i_pwm_event_source,
  input wire logic i_sw_trigger,
  input wire logic i_external_start_pin,
  input wire logic i_stop,
  input wire logic [dcs_pkg::DATA_W-1:0] i_analog_a,
  input wire logic [dcs_pkg::DATA_W-1:0] i_analog_b,
  output logic o_converter_clock,
  output logic o_sample_hold,
  output logic o_busy,
  output logic [dcs_pkg::DATA_W-1:0] o_result_a,
  output logic [dcs_pkg::DATA_W-1:0] o_result_b,
  output logic o_result_a_upd,
  output logic o_result_b_upd,
  output logic [dcs_pkg::CH_W:0] o_result_ch,
  output logic o_flag
);
  dcs_pkg::dcs_state_type state_q;
  logic [7:0] div_q;
  logic half_en;
  logic phase_q;
  // sample stages, one per half converter clock; B leaves at the last
  localparam int PIPE_N = 2 * dcs_pkg::LAT_B_FIRST;
  localparam int TAP_A = 2 * dcs_pkg::LAT_A_FIRST - 1;
  localparam int TAP_B = 2 * dcs_pkg::LAT_B_FIRST - 1;
  // gap after a pulse in half periods: two clocks dual, one single
  localparam int GAP_DUAL = 2 * (dcs_pkg::LAT_NEXT_BASE - 1) - 1;
  localparam int GAP_SEQ = 2 * (dcs_pkg::LAT_SEQ_NEXT_BASE - 1) - 1;
  logic [4:0] cnt_q;
  logic [dcs_pkg::ACQ_W-1:0] acq_q;
  logic dual_q;
  logic cont_q;
  logic [dcs_pkg::CH_W:0] ch_q;
  logic [PIPE_N-1:0] vld_q;
  logic [dcs_pkg::DATA_W-1:0] pipe_a_q [PIPE_N];
  logic [dcs_pkg::DATA_W-1:0] pipe_b_q [PIPE_N];
  logic capture;
  logic pending;
  logic upd_any;
  logic start;

  // refuse a divider the half-period counter cannot serve
  if (DIV < 2 || DIV % 2 != 0 || DIV > 255) begin : g_bad_div
    $error("bad divider");
  end

  assign start = i_pwm_event_source | i_sw_trigger | i_external_start_pin;

  // falling edge of the hold pulse; samples still in flight
  assign capture = (state_q == dcs_pkg::DCS_HOLD) && half_en
                   && (cnt_q == 5'h00);
  assign pending = |vld_q;

  // half-period enable of the converter clock
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      div_q <= 8'h00;
      phase_q <= 1'b0;
      o_converter_clock <= 1'b0;
    end else if (half_en) begin
      div_q <= 8'h00;
      phase_q <= ~phase_q;
      o_converter_clock <= ~phase_q;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end
  assign half_en = (div_q == 8'((DIV / 2) - 1));

  // main sequence: delay, hold pulse, conversion spacing
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state_q <= dcs_pkg::DCS_IDLE;
      cnt_q <= 5'h00;
      acq_q <= '0;
      dual_q <= 1'b0;
      cont_q <= 1'b0;
      ch_q <= '0;
      o_sample_hold <= 1'b0;
      o_busy <= 1'b0;
    end else begin
      case (state_q)
        dcs_pkg::DCS_IDLE: begin
          if (start) begin
            acq_q <= i_ctrl_one[dcs_pkg::ACQ_LSB +: dcs_pkg::ACQ_W];
            dual_q <= i_dual_sample_select;
            ch_q <= i_dual_sample_select ? {1'b0, i_channel[2:0]}
                                         : i_channel;
            cont_q <= i_continuous;
            cnt_q <= 5'(dcs_pkg::START_DLY_HALF - 1);
            o_busy <= 1'b1;
            state_q <= dcs_pkg::DCS_DELAY;
          end
        end
        dcs_pkg::DCS_DELAY: begin
          // count 2.5 clocks in half periods, then open the pulse
          if (half_en) begin
            if (cnt_q == 5'h00) begin
              o_sample_hold <= 1'b1;
              cnt_q <= 5'(2 * acq_q + 1);
              state_q <= dcs_pkg::DCS_HOLD;
            end else begin
              cnt_q <= cnt_q - 5'h01;
            end
          end
        end
        dcs_pkg::DCS_HOLD: begin
          // pulse is (1 + acq) clocks, 2*(1+acq) half periods
          if (capture) begin
            o_sample_hold <= 1'b0;
            // gap sets the spacing of successive results
            cnt_q <= dual_q ? 5'(GAP_DUAL) : 5'(GAP_SEQ);
            state_q <= dcs_pkg::DCS_CONV;
          end else if (half_en) begin
            cnt_q <= cnt_q - 5'h01;
          end
        end
        dcs_pkg::DCS_CONV: begin
          // next pulse once the gap has run out
          if (i_stop || !cont_q) begin
            if (!pending) begin
              o_busy <= 1'b0;
              state_q <= dcs_pkg::DCS_IDLE;
            end
          end else if (half_en) begin
            if (cnt_q == 5'h00) begin
              o_sample_hold <= 1'b1;
              cnt_q <= 5'(2 * acq_q + 1);
              state_q <= dcs_pkg::DCS_HOLD;
            end else begin
              cnt_q <= cnt_q - 5'h01;
            end
          end
        end
        default: state_q <= dcs_pkg::DCS_IDLE;
      endcase
    end
  end

  // both inputs enter stage zero together at the falling edge
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      for (int k = 0; k < PIPE_N; k++) begin
        pipe_a_q[k] <= '0;
        pipe_b_q[k] <= '0;
      end
    end else if (half_en) begin
      pipe_a_q[0] <= capture ? i_analog_a : '0;
      pipe_b_q[0] <= capture ? i_analog_b : '0;
      for (int k = 1; k < PIPE_N; k++) begin
        pipe_a_q[k] <= pipe_a_q[k-1];
        pipe_b_q[k] <= pipe_b_q[k-1];
      end
    end
  end

  // each sample walks one stage per half converter clock
  // so a new pulse never cancels results still in flight
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      vld_q <= '0;
    end else if (half_en) begin
      vld_q <= {vld_q[PIPE_N-2:0], capture};
    end
  end

  // result registers, A then B one converter clock later
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_result_a <= '0;
      o_result_b <= '0;
      o_result_a_upd <= 1'b0;
      o_result_b_upd <= 1'b0;
      o_result_ch <= '0;
    end else begin
      o_result_a_upd <= 1'b0;
      o_result_b_upd <= 1'b0;
      // A result four clocks after its sample
      if (half_en && vld_q[TAP_A]) begin
        o_result_a <= pipe_a_q[TAP_A];
        o_result_a_upd <= 1'b1;
        o_result_ch <= ch_q;
      end
      // B result one clock later, dual mode only
      if (half_en && dual_q && vld_q[TAP_B]) begin
        o_result_b <= pipe_b_q[TAP_B];
        o_result_b_upd <= 1'b1;
      end
    end
  end

  // flag after the last update of the pulse
  assign upd_any = dual_q ? o_result_b_upd : o_result_a_upd;

  dcs_delay_line #(
    .DEPTH(FLAG_DELAY)
  ) u_flag_dly (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_pulse(upd_any),
    .o_pulse(o_flag)
  );
endmodule : dcs_sequencer

// ==== verif/dcs_src_model.sv ====
`timescale 1ns/10ps
// analog source: a fresh a/b pair on every new hold pulse
module dcs_src_model (
  input wire logic i_mclk,
  input wire logic i_sample_hold,
  output logic [dcs_pkg::DATA_W-1:0] o_analog_a,
  output logic [dcs_pkg::DATA_W-1:0] o_analog_b
);
  logic hold_q = 1'b0;
  logic [dcs_pkg::DATA_W-1:0] a_q = 12'h5C3;
  logic [dcs_pkg::DATA_W-1:0] b_q = 12'h1E7;
  assign o_analog_a = a_q;
  assign o_analog_b = b_q;
  always @(posedge i_mclk) begin
    hold_q <= i_sample_hold;
    if (i_sample_hold && !hold_q) begin
      a_q <= a_q + 12'h3A5;
      b_q <= ~a_q;
    end
  end
endmodule : dcs_src_model

// ==== verif/dcs_sequencer_sva.sv ====
`timescale 1ns/10ps
module dcs_sequencer_sva #(
  parameter int DIV = 8
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [dcs_pkg::CTRL_W-1:0] i_ctrl_one,
  input wire logic i_dual_sample_select,
  input wire logic i_continuous,
  input wire logic i_stop,
  input wire logic i_pwm_event_source,
  input wire logic i_sw_trigger,
  input wire logic i_external_start_pin,
  input wire logic o_converter_clock,
  input wire logic o_sample_hold,
  input wire logic o_busy,
  input wire logic o_result_a_upd,
  input wire logic o_result_b_upd,
  input wire logic o_flag
);
  localparam int LA = 4 * DIV;
  // fall to next rise: two converter clocks dual, one single
  localparam int GAP_D = 2 * DIV;
  localparam int GAP_S = DIV;
  logic [7:0] hold_q;
  wire logic go;
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);
  // any start source
  assign go = i_pwm_event_source | i_sw_trigger | i_external_start_pin;
  // cycles the hold pulse has lasted
  always_ff @(posedge i_mclk) begin
    if (i_rst || !o_sample_hold) hold_q <= 8'h00;
    else hold_q <= hold_q + 8'h01;
  end
  sequence s_pair;
    ##LA o_result_a_upd ##DIV o_result_b_upd ##2 o_flag;
  endsequence
  sequence s_one;
    ##LA o_result_a_upd ##2 o_flag;
  endsequence
  a_first_pair: assert property (
    $fell(o_sample_hold) && i_dual_sample_select && !i_continuous
    |-> s_pair) else $error("pair results late");
  a_first_one: assert property (
    $fell(o_sample_hold) && !i_dual_sample_select && !i_continuous
    |-> s_one) else $error("single result late");
  a_no_b_single: assert property (
    o_result_b_upd |-> i_dual_sample_select) else $error("b in single");
  a_hold_width: assert property (
    $fell(o_sample_hold) |-> hold_q == DIV * (i_ctrl_one[11:8] + 1))
    else $error("hold width wrong");
  a_start_delay: assert property (
    go && !o_busy |=> o_busy ##[17:20] $rose(o_sample_hold))
    else $error("start to hold wrong");
  a_flag_cause: assert property (
    o_flag |-> $past(o_result_b_upd, 2) || $past(o_result_a_upd, 2)
    && !i_dual_sample_select) else $error("flag without update");
  a_cont_period: assert property (
    $fell(o_sample_hold) && i_continuous && !i_stop && i_dual_sample_select
    |-> ##GAP_D $rose(o_sample_hold)) else $error("period wrong");
  a_cont_single: assert property (
    $fell(o_sample_hold) && i_continuous && !i_stop && !i_dual_sample_select
    |-> ##GAP_S $rose(o_sample_hold)) else $error("single period wrong");
  a_conv_clock: assert property (
    $changed(o_converter_clock) |=> $stable(o_converter_clock) [*3]
    ##1 $changed(o_converter_clock)) else $error("converter clock wrong");
  a_hold_busy: assert property (
    o_sample_hold |-> o_busy) else $error("hold while idle");
endmodule : dcs_sequencer_sva
bind dcs_sequencer dcs_sequencer_sva #(.DIV(DIV)) dcs_sequencer_sva_i (.*);

// ==== verif/dcs_sequencer_tb_top.sv ====
`timescale 1ns/10ps
module dcs_sequencer_tb_top;
  logic mclk = 1'b0, rst = 1'b1, dual = 1'b0, cont = 1'b0, stop = 1'b0;
  logic pwm = 1'b0, sw = 1'b0, ext = 1'b0;
  logic [15:0] ctrl = 16'h0000;
  logic [3:0] ch = 4'h0;
  logic [3:0] rch;
  logic [11:0] a, b, ra, rb;
  logic hold, busy, aupd, bupd, flag;
  int mismatches = 0;
  int compares = 0;
  int cyc = 0;
  dcs_sequencer dcs_sequencer_i (
    .i_mclk(mclk), .i_rst(rst), .i_ctrl_one(ctrl),
    .i_dual_sample_select(dual), .i_continuous(cont), .i_channel(ch),
    .i_pwm_event_source(pwm), .i_sw_trigger(sw),
    .i_external_start_pin(ext), .i_stop(stop), .i_analog_a(a),
    .i_analog_b(b), .o_converter_clock(), .o_sample_hold(hold),
    .o_busy(busy), .o_result_a(ra), .o_result_b(rb),
    .o_result_a_upd(aupd), .o_result_b_upd(bupd), .o_result_ch(rch),
    .o_flag(flag)
  );
  dcs_src_model dcs_src_model_i (
    .i_mclk(mclk), .i_sample_hold(hold), .o_analog_a(a), .o_analog_b(b)
  );
  // system clock and hang guard
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 8000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic check(input logic [11:0] s, input logic [11:0] e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : check
  task automatic report_and_stop();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  task automatic idle();
    int n = 0;
    while (busy !== 1'b0 && n < 600) begin
      @(posedge mclk);
      n++;
    end
    check(12'(n < 600), 12'h001);
  endtask : idle
  // one run from source src, a second start while busy is refused
  task automatic run(input int src, input logic d, input logic [3:0] q,
                     input logic [3:0] c);
    int n = 0;
    logic [11:0] na = 12'h000;
    logic [11:0] nb = 12'h000;
    @(posedge mclk);
    dual <= d;
    ctrl <= {4'h0, q, 8'h00};
    ch <= c;
    @(posedge mclk);
    pwm <= (src == 0);
    sw <= (src == 1);
    ext <= (src == 2);
    @(posedge mclk);
    pwm <= 1'b0;
    ext <= 1'b0;
    sw <= 1'b1;
    @(posedge mclk);
    sw <= 1'b0;
    while (flag !== 1'b1 && n < 400) begin
      @(posedge mclk);
      n++;
      if (aupd === 1'b1) na++;
      if (bupd === 1'b1) nb++;
    end
    check(12'(n < 400), 12'h001);
    check(na, 12'h001);
    check(nb, 12'(d));
    check(ra, a);
    if (d) check(rb, b);
    check(12'(rch), d ? 12'(c[2:0]) : 12'(c));
    idle();
  endtask : run
  task automatic t_pairs();
    for (int i = 0; i < 3; i++) run(i, 1'b1, 4'(i * 15 / 2), 4'(i * 7 / 2 + 8));
  endtask : t_pairs
  task automatic t_single();
    run(1, 1'b0, 4'h2, 4'hB);
  endtask : t_single
  // repeated pulses, result spacing, stop raised while a pulse is high
  task automatic t_cont(input logic d);
    int n = 0;
    int m = 0;
    @(posedge mclk);
    dual <= d;
    cont <= 1'b1;
    ctrl <= 16'h0100;
    sw <= 1'b1;
    @(posedge mclk);
    sw <= 1'b0;
    while (!(aupd === 1'b1 && n > 150) && n < 600) begin
      @(posedge mclk);
      n++;
    end
    @(posedge mclk);
    while (aupd !== 1'b1 && m < 200) begin
      @(posedge mclk);
      m++;
    end
    // acq 1: (3 + 1) clocks dual, (2 + 1) single, 8 cycles a clock
    check(12'(m + 1), d ? 12'h020 : 12'h018);
    while (hold !== 1'b1 && n < 700) begin
      @(posedge mclk);
      n++;
    end
    stop <= 1'b1;
    check(12'(n < 700), 12'h001);
    idle();
    check(ra, a);
    cont <= 1'b0;
    stop <= 1'b0;
  endtask : t_cont
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    t_pairs();
    t_single();
    t_cont(1'b1);
    t_cont(1'b0);
    report_and_stop();
  end
endmodule : dcs_sequencer_tb_top
